// [vram_ctl_pkg.sv]
// Constants, pin bundle and cycle decode for the video DRAM transfer controller.
package vram_ctl_pkg;

    localparam int CLK_MHZ = 25;
    localparam int T_PHASE_NS = 80;
    localparam int PHASE_CYC = (T_PHASE_NS * CLK_MHZ + 999) / 1000;
    localparam int SC_PERIOD_NS = 320;
    localparam int SC_HALF_CYC = (SC_PERIOD_NS * CLK_MHZ / 1000) / 2;
    localparam logic [7:0] GUARD_BITS = 8'h04;

    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ROW = 8'h04;
    localparam logic [7:0] REG_COL = 8'h08;
    localparam logic [7:0] REG_DATA = 8'h0c;
    localparam logic [7:0] REG_COLMASK = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_SERIAL = 8'h18;
    localparam logic [7:0] REG_POS = 8'h1c;

    localparam int ST_BUSY = 0;
    localparam int ST_ERR = 1;
    localparam int ST_RT_DONE = 2;
    localparam int ST_MWT_DONE = 3;
    localparam int ST_DIR_IN = 4;
    localparam int ST_HALF = 5;
    localparam int ST_OLD_MASK = 6;
    localparam int ST_COLOR = 7;
    localparam int ST_SPLIT_PEND = 8;

    localparam logic [3:0] OP_RT = 4'h0;
    localparam logic [3:0] OP_SRT = 4'h1;
    localparam logic [3:0] OP_MWT = 4'h2;
    localparam logic [3:0] OP_MASKED_SPLIT_WRITE_TRANSFER = 4'h3;
    localparam logic [3:0] OP_REFRESH_STOP_SET = 4'h4;
    localparam logic [3:0] OP_REFRESH_OPTION_RESET = 4'h5;
    localparam logic [3:0] OP_WR = 4'h6;
    localparam logic [3:0] OP_MWR = 4'h7;
    localparam logic [3:0] OP_BW = 4'h8;
    localparam logic [3:0] OP_MBW = 4'h9;
    localparam logic [3:0] OP_FLASH = 4'ha;
    localparam logic [3:0] OP_LMR = 4'hb;
    localparam logic [3:0] OP_LCR = 4'hc;

    localparam logic [3:0] STOP_1 = 4'hf;
    localparam logic [3:0] STOP_2 = 4'h7;
    localparam logic [3:0] STOP_4 = 4'h3;
    localparam logic [3:0] STOP_8 = 4'h1;
    localparam logic [3:0] STOP_16 = 4'h0;
    localparam logic [8:0] LAST_ADDR = 9'h1ff;

    typedef struct packed {
        logic ras_n;
        logic cas_n;
        logic [8:0] addr;
        logic transfer_output_enable_n;
        logic write_bitmask_enable_n;
        logic special_function_select;
        logic [7:0] mask_out;
        logic mask_oe;
    } pins_t;

    typedef struct packed {
        logic toe_n;
        logic wb_n;
        logic dsf_ras;
        logic dsf_cas;
        logic cbr;
        logic masked;
        logic cas_drive;
    } cyc_t;

    function automatic cyc_t decode_op(input logic [3:0] op);
        cyc_t c;
        c = '{toe_n: 1'b1, wb_n: 1'b1, dsf_ras: 1'b0, dsf_cas: 1'b0, cbr: 1'b0, masked: 1'b0, cas_drive: 1'b0};
        case (op)
            OP_RT: c.toe_n = 1'b0;
            OP_SRT: begin c.toe_n = 1'b0; c.dsf_ras = 1'b1; end
            OP_MWT: begin c.toe_n = 1'b0; c.wb_n = 1'b0; c.masked = 1'b1; end
            OP_MASKED_SPLIT_WRITE_TRANSFER: begin c.toe_n = 1'b0; c.wb_n = 1'b0; c.dsf_ras = 1'b1; c.masked = 1'b1; end
            OP_REFRESH_STOP_SET: begin c.cbr = 1'b1; c.wb_n = 1'b0; c.dsf_ras = 1'b1; end
            OP_REFRESH_OPTION_RESET: c.cbr = 1'b1;
            OP_WR: c.cas_drive = 1'b1;
            OP_MWR: begin c.wb_n = 1'b0; c.masked = 1'b1; c.cas_drive = 1'b1; end
            OP_BW: begin c.dsf_cas = 1'b1; c.cas_drive = 1'b1; end
            OP_MBW: begin c.wb_n = 1'b0; c.masked = 1'b1; c.dsf_cas = 1'b1; c.cas_drive = 1'b1; end
            OP_FLASH: begin c.wb_n = 1'b0; c.dsf_ras = 1'b1; c.masked = 1'b1; end
            OP_LMR: begin c.dsf_ras = 1'b1; c.cas_drive = 1'b1; end
            OP_LCR: begin c.dsf_ras = 1'b1; c.dsf_cas = 1'b1; c.cas_drive = 1'b1; end
            default: c.cbr = 1'b0;
        endcase
        return c;
    endfunction

    function automatic logic stop_code_ok(input logic [3:0] code);
        return (code == STOP_1) || (code == STOP_2) || (code == STOP_4) || (code == STOP_8) || (code == STOP_16);
    endfunction

    function automatic logic [7:0] part_mask(input logic [3:0] code);
        return {code, 4'hf};
    endfunction

endpackage

// [pin_sync.sv]
// Two flip-flop synchroniser for a level arriving from outside the clock domain.
`timescale 1ns/1ps
module pin_sync (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic async_in,
    output logic sync_out
);

    logic meta_r;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta_r <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

// [vram_xfer_ctl.sv]
// Controller that drives the video DRAM strobes, mode pins and serial clock for transfers and writes.
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
module vram_xfer_ctl (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output vram_ctl_pkg::pins_t vram_pins,
    output logic serial_shift_clock,
    input wire logic half_select_flag
);

    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_SETUP = 6'b000010,
        S_RAS = 6'b000100,
        S_CAS = 6'b001000,
        S_END = 6'b010000,
        S_PRE = 6'b100000
    } state_t;

    state_t state_r;
    vram_ctl_pkg::cyc_t cyc;
    logic [3:0] op_r;
    logic pending_r;
    logic [8:0] row_r;
    logic [8:0] col_r;
    logic [7:0] data_r;
    logic [3:0] colmask_r;
    logic serial_en_r;
    logic err_r;
    logic rt_done_r;
    logic mwt_done_r;
    logic dir_in_r;
    logic old_mask_r;
    logic color_r;
    logic [3:0] stop_pend_r;
    logic [3:0] stop_active_r;
    logic split_pend_r;
    logic [7:0] split_tap_r;
    logic [8:0] pos_r;
    logic [7:0] phase_r;
    logic [7:0] sc_cnt_r;
    logic sc_rise;
    logic half_sync;
    logic phase_done;
    logic is_split;
    logic near_stop;
    logic cmd_ok;
    logic [3:0] new_op;
    logic [7:0] wmask;
    logic [8:0] col_drive;
    logic finish;

    assign cyc = vram_ctl_pkg::decode_op(op_r);
    assign phase_done = (phase_r == 8'(vram_ctl_pkg::PHASE_CYC - 1));
    assign is_split = (op_r == vram_ctl_pkg::OP_SRT) || (op_r == vram_ctl_pkg::OP_MASKED_SPLIT_WRITE_TRANSFER);
    assign wmask = vram_ctl_pkg::part_mask(stop_active_r);
    assign near_stop = serial_en_r && ((wmask - (pos_r[7:0] & wmask)) < vram_ctl_pkg::GUARD_BITS);
    assign new_op = reg_wdata[3:0];
    assign finish = (state_r == S_END) && phase_done;

    always_comb begin
        if (is_split) begin
            col_drive = {1'b0, col_r[7:0]};
        end else if (cyc.dsf_cas) begin
            col_drive = {col_r[8:2], 2'b00};
        end else begin
            col_drive = col_r;
        end
    end

    always_comb begin
        cmd_ok = (new_op <= vram_ctl_pkg::OP_LCR) && !pending_r;
        if ((new_op == vram_ctl_pkg::OP_SRT) && !rt_done_r) begin
            cmd_ok = 1'b0;
        end
        if ((new_op == vram_ctl_pkg::OP_MASKED_SPLIT_WRITE_TRANSFER) && !mwt_done_r) begin
            cmd_ok = 1'b0;
        end
        if ((new_op == vram_ctl_pkg::OP_REFRESH_STOP_SET) && !vram_ctl_pkg::stop_code_ok(row_r[7:4])) begin
            cmd_ok = 1'b0;
        end
        if ((new_op == vram_ctl_pkg::OP_FLASH) && !color_r) begin
            cmd_ok = 1'b0;
        end
    end

    pin_sync u_half_sync (
        .clk(clk),
        .reset_n(reset_n),
        .async_in(half_select_flag),
        .sync_out(half_sync)
    );

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            row_r <= 9'h000;
            col_r <= 9'h000;
            data_r <= 8'h00;
            colmask_r <= 4'h0;
            serial_en_r <= 1'b0;
        end else if (reg_wr) begin
            case (reg_addr)
                vram_ctl_pkg::REG_ROW: row_r <= reg_wdata[8:0];
                vram_ctl_pkg::REG_COL: col_r <= reg_wdata[8:0];
                vram_ctl_pkg::REG_DATA: data_r <= reg_wdata[7:0];
                vram_ctl_pkg::REG_COLMASK: colmask_r <= reg_wdata[3:0];
                vram_ctl_pkg::REG_SERIAL: serial_en_r <= reg_wdata[0];
                default: serial_en_r <= serial_en_r;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pending_r <= 1'b0;
            op_r <= vram_ctl_pkg::OP_RT;
            err_r <= 1'b0;
        end else if (reg_wr && (reg_addr == vram_ctl_pkg::REG_CMD)) begin
            if (cmd_ok) begin
                pending_r <= 1'b1;
                op_r <= new_op;
                err_r <= 1'b0;
            end else begin
                err_r <= 1'b1;
            end
        end else if (finish) begin
            pending_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_r <= S_IDLE;
            phase_r <= 8'h00;
            vram_pins <= '{ras_n: 1'b1, cas_n: 1'b1, addr: 9'h000, transfer_output_enable_n: 1'b1,
                           write_bitmask_enable_n: 1'b1, special_function_select: 1'b0,
                           mask_out: 8'h00, mask_oe: 1'b0};
        end else begin
            phase_r <= (phase_done || (state_r == S_IDLE)) ? 8'h00 : phase_r + 8'h01;
            case (state_r)
                S_IDLE: begin
                    if (pending_r && !(is_split && near_stop)) begin
                        state_r <= S_SETUP;
                        vram_pins.addr <= row_r;
                        vram_pins.transfer_output_enable_n <= cyc.toe_n;
                        vram_pins.write_bitmask_enable_n <= cyc.wb_n;
                        vram_pins.special_function_select <= cyc.dsf_ras;
                        vram_pins.mask_out <= data_r;
                        vram_pins.mask_oe <= cyc.masked && !old_mask_r;
                        vram_pins.cas_n <= !cyc.cbr;
                    end
                end
                S_SETUP: begin
                    if (phase_done) begin
                        state_r <= S_RAS;
                        vram_pins.ras_n <= 1'b0;
                    end
                end
                S_RAS: begin
                    if (phase_done) begin
                        state_r <= cyc.cbr ? S_END : S_CAS;
                        vram_pins.addr <= cyc.cbr ? vram_pins.addr : col_drive;
                        vram_pins.special_function_select <= cyc.dsf_cas;
                        vram_pins.mask_out <= cyc.dsf_cas ? {4'h0, colmask_r} : data_r;
                        vram_pins.mask_oe <= cyc.cas_drive;
                    end
                end
                S_CAS: begin
                    if (phase_done) begin
                        state_r <= S_END;
                        vram_pins.cas_n <= 1'b0;
                        vram_pins.transfer_output_enable_n <= 1'b1;
                    end
                end
                S_END: begin
                    if (phase_done) begin
                        state_r <= S_PRE;
                        vram_pins.ras_n <= 1'b1;
                        vram_pins.cas_n <= 1'b1;
                        vram_pins.mask_oe <= 1'b0;
                        vram_pins.transfer_output_enable_n <= 1'b1;
                    end
                end
                S_PRE: begin
                    if (phase_done) begin
                        state_r <= S_IDLE;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rt_done_r <= 1'b0;
            mwt_done_r <= 1'b0;
            dir_in_r <= 1'b0;
            old_mask_r <= 1'b0;
            color_r <= 1'b0;
        end else if (finish) begin
            case (op_r)
                vram_ctl_pkg::OP_RT: begin rt_done_r <= 1'b1; dir_in_r <= 1'b0; end
                vram_ctl_pkg::OP_MWT: begin mwt_done_r <= 1'b1; dir_in_r <= 1'b1; end
                vram_ctl_pkg::OP_LMR: old_mask_r <= 1'b1;
                vram_ctl_pkg::OP_LCR: color_r <= 1'b1;
                vram_ctl_pkg::OP_REFRESH_OPTION_RESET: old_mask_r <= 1'b0;
                default: dir_in_r <= dir_in_r;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            stop_pend_r <= vram_ctl_pkg::STOP_1;
            stop_active_r <= vram_ctl_pkg::STOP_1;
        end else if (finish) begin
            if (op_r == vram_ctl_pkg::OP_REFRESH_STOP_SET) begin
                stop_pend_r <= row_r[7:4];
            end else if (op_r == vram_ctl_pkg::OP_REFRESH_OPTION_RESET) begin
                stop_pend_r <= vram_ctl_pkg::STOP_1;
                stop_active_r <= vram_ctl_pkg::STOP_1;
            end else if (op_r == vram_ctl_pkg::OP_SRT) begin
                stop_active_r <= stop_pend_r;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sc_cnt_r <= 8'h00;
            serial_shift_clock <= 1'b0;
            sc_rise <= 1'b0;
        end else begin
            sc_rise <= 1'b0;
            if (!serial_en_r) begin
                sc_cnt_r <= 8'h00;
                serial_shift_clock <= 1'b0;
            end else if (sc_cnt_r == 8'(vram_ctl_pkg::SC_HALF_CYC - 1)) begin
                sc_cnt_r <= 8'h00;
                serial_shift_clock <= !serial_shift_clock;
                sc_rise <= !serial_shift_clock;
            end else begin
                sc_cnt_r <= sc_cnt_r + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pos_r <= 9'h000;
            split_pend_r <= 1'b0;
            split_tap_r <= 8'h00;
        end else begin
            if (sc_rise) begin
                if (split_pend_r && ((pos_r[7:0] & wmask) == wmask)) begin
                    pos_r <= {!pos_r[8], split_tap_r};
                    split_pend_r <= 1'b0;
                end else if (pos_r == vram_ctl_pkg::LAST_ADDR) begin
                    pos_r <= 9'h000;
                end else begin
                    pos_r <= pos_r + 9'h001;
                end
            end
            if (finish && ((op_r == vram_ctl_pkg::OP_RT) || (op_r == vram_ctl_pkg::OP_MWT))) begin
                pos_r <= col_r;
                split_pend_r <= 1'b0;
            end else if (finish && is_split) begin
                split_pend_r <= 1'b1;
                split_tap_r <= col_r[7:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                vram_ctl_pkg::REG_ROW: reg_rdata <= {23'h000000, row_r};
                vram_ctl_pkg::REG_COL: reg_rdata <= {23'h000000, col_r};
                vram_ctl_pkg::REG_DATA: reg_rdata <= {24'h000000, data_r};
                vram_ctl_pkg::REG_COLMASK: reg_rdata <= {28'h0000000, colmask_r};
                vram_ctl_pkg::REG_SERIAL: reg_rdata <= {31'h00000000, serial_en_r};
                vram_ctl_pkg::REG_POS: reg_rdata <= {15'h0000, stop_active_r, stop_pend_r, pos_r};
                vram_ctl_pkg::REG_STATUS: reg_rdata <= {23'h000000, split_pend_r, color_r, old_mask_r, half_sync,
                                                        dir_in_r, mwt_done_r, rt_done_r, err_r, pending_r};
                default: reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    split_order_a: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(vram_pins.ras_n) && !vram_pins.transfer_output_enable_n && vram_pins.write_bitmask_enable_n
        && vram_pins.special_function_select |-> rt_done_r)
        else $error("split read issued before full read transfer");

    masked_split_write_transfer_order_a: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(vram_pins.ras_n) && !vram_pins.transfer_output_enable_n && !vram_pins.write_bitmask_enable_n
        && vram_pins.special_function_select |-> mwt_done_r)
        else $error("masked split write issued before masked write transfer");

    split_window_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_r == S_IDLE) && pending_r && is_split && near_stop |=> state_r == S_IDLE)
        else $error("split transfer started inside stop window");

    cbr_order_a: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(vram_pins.ras_n) && !vram_pins.cas_n |-> $past(!vram_pins.cas_n, 2))
        else $error("column strobe not ahead of row strobe in refresh");

    stop_code_a: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(vram_pins.ras_n) && !vram_pins.cas_n && !vram_pins.write_bitmask_enable_n
        |-> vram_ctl_pkg::stop_code_ok(vram_pins.addr[7:4]))
        else $error("illegal stop code driven");

    block_col_a: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(vram_pins.cas_n) && !vram_pins.ras_n && vram_pins.special_function_select
        && vram_pins.transfer_output_enable_n |-> vram_pins.addr[1:0] == 2'b00)
        else $error("block write column low bits not zero");

    split_col_a: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(vram_pins.cas_n) && is_split |-> !vram_pins.addr[8])
        else $error("split transfer column msb driven high");

    dir_in_a: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(vram_pins.ras_n) && (op_r == vram_ctl_pkg::OP_MWT) |-> ##[1:12] dir_in_r)
        else $error("serial direction not set after write transfer");

    wrap_a: assert property (@(posedge clk) disable iff (!reset_n)
        sc_rise && !split_pend_r && (pos_r == vram_ctl_pkg::LAST_ADDR) && !finish |=> pos_r == 9'h000)
        else $error("serial position did not wrap");

    jump_a: assert property (@(posedge clk) disable iff (!reset_n)
        sc_rise && split_pend_r && ((pos_r[7:0] & wmask) == wmask) && !finish
        |=> (pos_r[7:0] == $past(split_tap_r)) && (pos_r[8] != $past(pos_r[8])))
        else $error("pending tap not taken at stop point");

    new_mask_a: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(vram_pins.ras_n) && !vram_pins.write_bitmask_enable_n && !vram_pins.cas_n == 1'b0
        && !old_mask_r |-> vram_pins.mask_oe)
        else $error("new mask not driven at row strobe fall");

endmodule

// [vram_dev_model.sv]
// Behavioural video DRAM that reports the shifting serial half.
`timescale 1ns/1ps
module vram_dev_model (
    input wire vram_ctl_pkg::pins_t pins,
    input wire logic serial_shift_clock,
    output logic half_select_flag
);
    logic [8:0] pos;
    logic full;
    initial begin
        pos = 9'h000;
        full = 1'b0;
        half_select_flag = 1'b0;
    end
    always @(negedge pins.ras_n) begin
        full = pins.cas_n && !pins.transfer_output_enable_n && !pins.special_function_select;
    end
    always @(negedge pins.cas_n) begin
        if (full && !pins.ras_n) begin
            pos = pins.addr;
            half_select_flag = pins.addr[8];
        end
    end
    always @(posedge serial_shift_clock) begin
        pos = pos + 9'h001;
        half_select_flag = pos[8];
    end
endmodule

// [vram_xfer_ctl_tb.sv]
// Register level testbench for the video DRAM transfer controller.
`timescale 1ns/1ps
module vram_xfer_ctl_tb;
    logic clk;
    logic reset_n;
    logic reg_wr;
    logic reg_rd;
    logic half_select_flag;
    logic serial_shift_clock;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic [31:0] rdv;
    vram_ctl_pkg::pins_t vram_pins;
    vram_ctl_pkg::pins_t rs;
    vram_ctl_pkg::pins_t cs;
    int error_cnt;
    int checks;
    int sc_cnt;
    int n;
    logic [3:0] ops [8] = '{4'hc, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'h7};
    logic [3:0] ex [8] = '{4'he, 4'h8, 4'h1, 4'ha, 4'h3, 4'h5, 4'hc, 4'h0};
    vram_xfer_ctl dut_u (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vram_pins(vram_pins),
        .serial_shift_clock(serial_shift_clock), .half_select_flag(half_select_flag));
    vram_dev_model dev_u (.pins(vram_pins), .serial_shift_clock(serial_shift_clock),
        .half_select_flag(half_select_flag));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(negedge vram_pins.ras_n) rs = vram_pins;
    always @(negedge vram_pins.cas_n) cs = vram_pins;
    always @(posedge serial_shift_clock) sc_cnt++;
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        rdv = reg_rdata;
    endtask
    task automatic go(input logic [3:0] op, input logic [8:0] col);
        int k;
        wr(vram_ctl_pkg::REG_COL, {23'h0, col});
        wr(vram_ctl_pkg::REG_CMD, {28'h0, op});
        k = 0;
        rd(vram_ctl_pkg::REG_STATUS);
        while (rdv[0] !== 1'b0 && k < 100) begin
            rd(vram_ctl_pkg::REG_STATUS);
            k++;
        end
        if (k == 100) begin
            error_cnt++;
            $display("Error at %0t: command never finished", $time);
            wrap_up();
        end
    endtask
    task automatic run_sc(input int rises);
        int w;
        sc_cnt = 0;
        wr(vram_ctl_pkg::REG_SERIAL, 32'h1);
        w = 0;
        while (sc_cnt < rises && w < rises * 10) begin
            @(posedge clk);
            w++;
        end
        if (sc_cnt < rises) begin
            error_cnt++;
            $display("Error at %0t: serial clock stalled", $time);
            wrap_up();
        end
        wr(vram_ctl_pkg::REG_SERIAL, 32'h0);
        repeat (10) @(posedge clk);
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        $display("Error at %0t: run timed out", $time);
        wrap_up();
    end
    initial begin
        reset_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        error_cnt = 0;
        checks = 0;
        sc_cnt = 0;
        repeat (8) @(posedge clk);
        chk(vram_pins, {1'b1, 1'b1, 9'h0, 1'b1, 1'b1, 1'b0, 8'h0, 1'b0});
        reset_n <= 1'b1;
        rd(8'h40);
        chk(rdv, 32'h0);
        go(4'h1, 9'h000);
        chk(rdv[1], 1'b1);
        go(4'h3, 9'h000);
        chk(rdv[1], 1'b1);
        rd(vram_ctl_pkg::REG_POS);
        chk(rdv[16:9], {vram_ctl_pkg::STOP_1, vram_ctl_pkg::STOP_1});
        wr(vram_ctl_pkg::REG_ROW, 32'h50);
        go(4'h4, 9'h000);
        chk(rdv[1], 1'b1);
        wr(vram_ctl_pkg::REG_ROW, 32'h30);
        go(4'h4, 9'h000);
        chk({rs.cas_n, rs.write_bitmask_enable_n, rs.special_function_select, rs.addr}, {3'b001, 9'h030});
        rd(vram_ctl_pkg::REG_POS);
        chk(rdv[16:9], {vram_ctl_pkg::STOP_1, vram_ctl_pkg::STOP_4});
        $display("refusal and stop set test done");
        go(4'h0, 9'h100);
        chk({rs.transfer_output_enable_n, rs.write_bitmask_enable_n, rs.special_function_select}, 3'b010);
        chk(rdv[5], 1'b1);
        wr(vram_ctl_pkg::REG_ROW, 32'haa);
        go(4'h1, 9'h1ab);
        chk({rs.transfer_output_enable_n, rs.write_bitmask_enable_n, rs.special_function_select, rs.addr}, 12'h6aa);
        chk(cs.addr, 9'h0ab);
        chk({rdv[8], rdv[4]}, 2'b10);
        rd(vram_ctl_pkg::REG_POS);
        chk({rdv[16:13], rdv[8:0]}, {vram_ctl_pkg::STOP_4, 9'h100});
        wr(vram_ctl_pkg::REG_DATA, 32'h5a);
        go(4'h2, 9'h000);
        chk({rs.transfer_output_enable_n, rs.write_bitmask_enable_n, rs.special_function_select, rs.mask_oe, rs.mask_out}, 12'h15a);
        chk({rdv[4], rdv[5]}, 2'b10);
        go(4'h3, 9'h1c0);
        chk({rs.transfer_output_enable_n, rs.write_bitmask_enable_n, rs.special_function_select, cs.addr}, 12'h2c0);
        chk(rdv[4], 1'b1);
        $display("transfer test done");
        wr(vram_ctl_pkg::REG_COLMASK, 32'h9);
        go(4'h8, 9'h1ff);
        chk({cs.addr, cs.mask_oe, cs.mask_out}, {9'h1fc, 1'b1, 8'h09});
        for (n = 0; n < 8; n++) begin
            go(ops[n], 9'h004);
            chk({rs.write_bitmask_enable_n, rs.special_function_select, cs.special_function_select, rs.mask_oe}, ex[n]);
        end
        chk(rdv[6], 1'b1);
        go(4'h5, 9'h000);
        chk({rs.cas_n, rs.special_function_select, rdv[6]}, 3'b000);
        rd(vram_ctl_pkg::REG_POS);
        chk(rdv[16:9], {vram_ctl_pkg::STOP_1, vram_ctl_pkg::STOP_1});
        $display("write decode test done");
        reset_n <= 1'b0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        go(4'h0, 9'h1fe);
        run_sc(4);
        chk(sc_cnt, 32'd4);
        rd(vram_ctl_pkg::REG_POS);
        chk(rdv[8:0], 9'h002);
        rd(vram_ctl_pkg::REG_STATUS);
        chk(rdv[5], 1'b0);
        go(4'h1, 9'h010);
        chk(rdv[8], 1'b1);
        run_sc(254);
        rd(vram_ctl_pkg::REG_POS);
        chk(rdv[8:0], 9'h110);
        rd(vram_ctl_pkg::REG_STATUS);
        chk({rdv[8], rdv[5]}, 2'b01);
        $display("serial wrap test done");
        wrap_up();
    end
endmodule
